// >>> hw/epsc_defs.svh
`ifndef EPSC_DEFS_SVH
`define EPSC_DEFS_SVH

// Fast clock period split into VCO phase steps
`define EPSC_VCO_TAPS 8
`define EPSC_HALF_TAPS 4
// Serialization factor and receiver width
`define EPSC_SER_FACTOR 8
`define EPSC_RX_CHANNELS 18
`define EPSC_SLICE_BITS 8
// Lock delay after reset
`define EPSC_CLK_PERIOD_NS 10
`define EPSC_LOCK_TIME_NS 1000
`define EPSC_LOCK_CYCLES ((`EPSC_LOCK_TIME_NS + `EPSC_CLK_PERIOD_NS - 1) / `EPSC_CLK_PERIOD_NS)
`define EPSC_LOCK_CNT_BITS 16
// Reset values
`define EPSC_RST_TICK 0
`define EPSC_RST_TAPS 8'h00

`endif

// >>> hw/epsc_deser.sv
`timescale 1ns/1ps
`default_nettype none
`include "epsc_defs.svh"

module epsc_deser #(
    parameter int CHANNELS = `EPSC_RX_CHANNELS,
    parameter int SLICE = `EPSC_SLICE_BITS
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [CHANNELS-1:0] ser_in,
    input wire epsc_pkg::epsc_clk_set_t clk_set,
    input wire logic core_clk,
    output logic [CHANNELS*SLICE-1:0] rx_parallel
);
    import epsc_pkg::*;

    logic fast_prev_r;
    logic core_prev_r;
    logic fall;
    logic core_rise;
    logic [CHANNELS*SLICE-1:0] shift_r, shift_nxt;
    logic [CHANNELS*SLICE-1:0] par_r, par_nxt;
    logic [CHANNELS*SLICE-1:0] out_nxt;

    assign fall = fast_prev_r & ~clk_set.fast_clk;
    assign core_rise = core_clk & ~core_prev_r;

    // Channel n owns bits 8n-8..8n-1, first bit lands in the MSB
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            always_comb begin
                shift_nxt[ch*SLICE +: SLICE] = shift_r[ch*SLICE +: SLICE];
                if (fall) begin
                    shift_nxt[ch*SLICE +: SLICE] = {shift_r[ch*SLICE +: SLICE-1], ser_in[ch]};
                end
            end
        end
    endgenerate

    always_comb begin
        par_nxt = par_r;
        out_nxt = rx_parallel;
        if (fall && clk_set.load_en) begin
            par_nxt = shift_nxt;
        end
        if (core_rise) begin
            out_nxt = par_r;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fast_prev_r <= 1'b0;
            core_prev_r <= 1'b0;
            shift_r <= '0;
            par_r <= '0;
            rx_parallel <= '0;
        end else begin
            fast_prev_r <= clk_set.fast_clk;
            core_prev_r <= core_clk;
            shift_r <= shift_nxt;
            par_r <= par_nxt;
            rx_parallel <= out_nxt;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    property p_sample_on_fall;
        fall |=> shift_r[0] == $past(ser_in[0]);
    endproperty
    a_sample_on_fall: assert property (p_sample_on_fall) else $error("Bit not sampled on fast clock fall");

    property p_no_sample_else;
        !fall |=> $stable(shift_r);
    endproperty
    a_no_sample_else: assert property (p_no_sample_else) else $error("Shift moved without a fall");

    property p_core_capture;
        core_rise |=> rx_parallel == $past(par_r);
    endproperty
    a_core_capture: assert property (p_core_capture) else $error("Word not captured on core clock");

endmodule : epsc_deser
`default_nettype wire

// >>> hw/epsc_pkg.sv
package epsc_pkg;

    typedef struct packed {
        logic dpa_en;
        logic soft_clock_data_recovery;
        logic multibank;
    } epsc_mode_t;

    typedef struct packed {
        logic fast_clk;
        logic load_en;
    } epsc_clk_set_t;

    typedef enum logic {
        LOCK_WAIT,
        LOCK_DONE
    } epsc_lock_state_t;

endpackage : epsc_pkg

// >>> hw/epsc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "epsc_defs.svh"

// Function
// - Fast serial clock runs at data rate, 180 degree shift, 50% duty.
// - Load strobe at word rate, phase (F-1)/F*360, high one bit period.
// - Core clock at word rate, phase 180/F degrees, 50% duty.
// - Eight VCO phase taps at data rate for alignment or recovery receivers.
// - Recovery receiver ignores load strobe; that output may stay unconnected.
// - Multibank transmitters get second fast clock and load; core from output four.
// - Fast clock equals reference word clock times the serialization factor.
// - Serial bits sampled on falling edge of fast clock.
// - Receiver channel n occupies parallel bits 8n-8 through 8n-1.
module epsc_top #(
    parameter int SER_FACTOR = `EPSC_SER_FACTOR,
    parameter int CHANNELS = `EPSC_RX_CHANNELS,
    parameter int SLICE = `EPSC_SLICE_BITS,
    parameter int TAPS = `EPSC_VCO_TAPS
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire epsc_pkg::epsc_mode_t mode,
    input wire logic [CHANNELS-1:0] rx_serial,
    output logic pll_output_zero,
    output logic pll_output_one,
    output logic pll_output_two,
    output logic pll_output_three,
    output logic pll_output_four,
    output logic [TAPS-1:0] vco_phase,
    output logic pll_locked,
    output logic [CHANNELS*SLICE-1:0] rx_parallel
);
    import epsc_pkg::*;

    localparam int WORD_TICKS = TAPS * SER_FACTOR;
    localparam int TW = $clog2(WORD_TICKS);
    localparam int HALF = `EPSC_HALF_TAPS;
    localparam logic [TW-1:0] TICK_LAST = TW'(WORD_TICKS - 1);
    localparam logic [TW-1:0] LOAD_START = TW'(TAPS * (SER_FACTOR - 1));
    localparam logic [TW-1:0] CORE_RISE = TW'(HALF);
    localparam logic [TW-1:0] CORE_FALL = TW'(HALF * SER_FACTOR + HALF);
    localparam logic [`EPSC_LOCK_CNT_BITS-1:0] LOCK_LAST = `EPSC_LOCK_CNT_BITS'(`EPSC_LOCK_CYCLES - 1);
    localparam int LD = TAPS * SER_FACTOR;
    localparam int CW = HALF * SER_FACTOR;

    // Tick counter: one fast clock period is TAPS ticks
    logic [TW-1:0] tick_r, tick_nxt;
    logic [2:0] phase;

    // Raw waveforms before mode gating
    epsc_clk_set_t set_raw;
    logic core_raw;
    logic [TAPS-1:0] taps_raw;

    // Registered outputs
    epsc_clk_set_t set0_r, set0_nxt;
    epsc_clk_set_t set1_r, set1_nxt;
    epsc_clk_set_t deser_set_r, deser_set_nxt;
    logic core_r, core_nxt;
    logic [TAPS-1:0] taps_r, taps_nxt;

    // Lock sequencing
    epsc_lock_state_t lock_st_r, lock_st_nxt;
    logic [`EPSC_LOCK_CNT_BITS-1:0] lock_cnt_r, lock_cnt_nxt;

    // Serial input synchroniser
    logic [CHANNELS-1:0] ser_meta_r;
    logic [CHANNELS-1:0] ser_sync_r;

    // Registered multibank select for output mux
    logic mode_mb_r;

    assign phase = tick_r[2:0];

    always_comb begin
        tick_nxt = (tick_r == TICK_LAST) ? '0 : tick_r + TW'(1);
    end

    always_comb begin
        set_raw.fast_clk = (phase >= 3'(HALF));
        set_raw.load_en = (tick_r >= LOAD_START);
        core_raw = (tick_r >= CORE_RISE) && (tick_r < CORE_FALL);
    end

    genvar k;
    generate
        for (k = 0; k < TAPS; k++) begin : g_tap
            always_comb begin
                taps_raw[k] = 3'(phase - 3'(k)) < 3'(HALF);
            end
        end
    endgenerate

    // Output selection by mode
    always_comb begin
        set0_nxt.fast_clk = set_raw.fast_clk;
        set0_nxt.load_en = set_raw.load_en & ~mode.soft_clock_data_recovery;
        set1_nxt = '0;
        deser_set_nxt = set_raw;
        core_nxt = core_raw;
        taps_nxt = '0;
        if (mode.multibank) begin
            set1_nxt = set_raw;
        end
        if (mode.dpa_en || mode.soft_clock_data_recovery) begin
            taps_nxt = taps_raw;
        end
    end

    always_comb begin
        lock_st_nxt = lock_st_r;
        lock_cnt_nxt = lock_cnt_r;
        case (lock_st_r)
            LOCK_WAIT: begin
                if (lock_cnt_r == LOCK_LAST) begin
                    lock_st_nxt = LOCK_DONE;
                end else begin
                    lock_cnt_nxt = lock_cnt_r + `EPSC_LOCK_CNT_BITS'(1);
                end
            end
            LOCK_DONE: begin
                lock_cnt_nxt = lock_cnt_r;
            end
            default: begin
                lock_st_nxt = LOCK_WAIT;
                lock_cnt_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_r <= TW'(`EPSC_RST_TICK);
            set0_r <= '0;
            set1_r <= '0;
            deser_set_r <= '0;
            core_r <= 1'b0;
            taps_r <= `EPSC_RST_TAPS;
            lock_st_r <= LOCK_WAIT;
            lock_cnt_r <= '0;
            ser_meta_r <= '0;
            ser_sync_r <= '0;
        end else begin
            tick_r <= tick_nxt;
            set0_r <= set0_nxt;
            set1_r <= set1_nxt;
            deser_set_r <= deser_set_nxt;
            core_r <= core_nxt;
            taps_r <= taps_nxt;
            lock_st_r <= lock_st_nxt;
            lock_cnt_r <= lock_cnt_nxt;
            ser_meta_r <= rx_serial;
            ser_sync_r <= ser_meta_r;
        end
    end

    // Output four carries core clock in multibank, else output two does
    assign pll_output_zero = set0_r.fast_clk;
    assign pll_output_one = set0_r.load_en;
    assign pll_output_two = mode_mb_r ? set1_r.fast_clk : core_r;
    assign pll_output_three = set1_r.load_en;
    assign pll_output_four = mode_mb_r ? core_r : 1'b0;
    assign vco_phase = taps_r;
    assign pll_locked = (lock_st_r == LOCK_DONE);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_mb_r <= 1'b0;
        end else begin
            mode_mb_r <= mode.multibank;
        end
    end

    epsc_deser #(
        .CHANNELS(CHANNELS),
        .SLICE(SLICE)
    ) u_deser (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .ser_in(ser_sync_r),
        .clk_set(deser_set_r),
        .core_clk(core_r),
        .rx_parallel(rx_parallel)
    );

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence s_fast_half_high;
        set0_r.fast_clk [*4];
    endsequence

    sequence s_fast_half_low;
        !set0_r.fast_clk [*4];
    endsequence

    property p_fast_duty;
        $rose(set0_r.fast_clk) |-> s_fast_half_high ##1 s_fast_half_low ##1 set0_r.fast_clk;
    endproperty
    a_fast_duty: assert property (p_fast_duty) else $error("Fast clock not 50 percent");

    property p_load_width;
        $rose(deser_set_r.load_en) |-> deser_set_r.load_en [*8] ##1 !deser_set_r.load_en;
    endproperty
    a_load_width: assert property (p_load_width) else $error("Load strobe not one bit wide");

    property p_load_rate;
        $rose(deser_set_r.load_en) |-> ##[LD:LD] $rose(deser_set_r.load_en);
    endproperty
    a_load_rate: assert property (p_load_rate) else $error("Load strobe not at word rate");

    property p_load_phase;
        $rose(deser_set_r.load_en) |-> $fell(deser_set_r.fast_clk);
    endproperty
    a_load_phase: assert property (p_load_phase) else $error("Load strobe phase wrong");

    property p_core_align;
        $rose(core_r) |-> $rose(deser_set_r.fast_clk);
    endproperty
    a_core_align: assert property (p_core_align) else $error("Core clock phase wrong");

    property p_core_duty;
        $rose(core_r) |-> ##[CW:CW] $fell(core_r);
    endproperty
    a_core_duty: assert property (p_core_duty) else $error("Core clock not 50 percent");

    property p_taps_on;
        $past(mode.dpa_en || mode.soft_clock_data_recovery) |-> (vco_phase[4] == set0_r.fast_clk) && (vco_phase[0] != set0_r.fast_clk);
    endproperty
    a_taps_on: assert property (p_taps_on) else $error("VCO taps misaligned");

    property p_taps_off;
        $past(!mode.dpa_en && !mode.soft_clock_data_recovery) |-> vco_phase == '0;
    endproperty
    a_taps_off: assert property (p_taps_off) else $error("VCO taps active when unused");

    property p_soft_clock_data_recovery_load;
        $past(mode.soft_clock_data_recovery) |-> !pll_output_one;
    endproperty
    a_soft_clock_data_recovery_load: assert property (p_soft_clock_data_recovery_load) else $error("Load strobe driven in recovery mode");

    property p_multibank;
        $past(mode.multibank) |-> (set1_r == set0_r || $past(mode.soft_clock_data_recovery)) && pll_output_four == core_r;
    endproperty
    a_multibank: assert property (p_multibank) else $error("Second clock set wrong");

    property p_lock_time;
        $rose(reset_n) |-> !pll_locked [*8];
    endproperty
    a_lock_time: assert property (p_lock_time) else $error("Lock raised too early");

endmodule : epsc_top
`default_nettype wire

// >>> tb/epsc_link_src.sv
`timescale 1ns/1ps
`default_nettype none

module epsc_link_src #(
    parameter int CH = 18
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic fast_clk,
    input wire logic [CH*8-1:0] words,
    output logic [CH-1:0] rx_serial
);
    logic fast_q;
    logic [2:0] idx;

    // Launch one bit per fast period, most significant first
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fast_q <= 1'b0;
            idx <= 3'h0;
            rx_serial <= '0;
        end else begin
            fast_q <= fast_clk;
            if (fast_q && !fast_clk) begin
                idx <= idx + 3'h1;
                for (int n = 0; n < CH; n++) begin
                    rx_serial[n] <= words[n*8+7-idx];
                end
            end
        end
    end
endmodule : epsc_link_src

`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import epsc_pkg::*;
    logic sys_clk;
    logic reset_n;
    epsc_mode_t mode;
    logic [17:0] rx_serial;
    logic [143:0] words;
    logic z, o, tw, th, fo, lk, fz, ld, cr;
    logic [7:0] vco;
    logic [7:0] tp;
    logic [143:0] rxp;
    logic [143:0] rxp_q;
    int fails, checks, ph, skip, since, r;
    bit anch;

    epsc_top i_dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .mode(mode), .rx_serial(rx_serial),
        .pll_output_zero(z), .pll_output_one(o), .pll_output_two(tw), .pll_output_three(th),
        .pll_output_four(fo), .vco_phase(vco), .pll_locked(lk), .rx_parallel(rxp)
    );

    epsc_link_src i_src (
        .sys_clk(sys_clk), .reset_n(reset_n), .fast_clk(z), .words(words), .rx_serial(rx_serial)
    );

    task automatic check(input logic [143:0] seen, input logic [143:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t mismatch %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    function automatic logic [7:0] rotl(input logic [7:0] w, input int k);
        rotl = (w << k) | (w >> (8 - k));
    endfunction : rotl

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Clock model, phased from the first load strobe
    always @(negedge sys_clk) begin
        if (!anch && o) begin
            anch = 1'b1;
            ph = 55;
        end
        if (anch) begin
            ph = (ph + 1) % 64;
            fz = (ph % 8) >= 4;
            ld = ph >= 56;
            cr = ph >= 4 && ph <= 35;
            for (int k = 0; k < 8; k++) begin
                tp[k] = (mode.dpa_en | mode.soft_clock_data_recovery) && (((ph % 8) - k + 8) % 8) < 4;
            end
            if (skip > 0) begin
                skip--;
            end else begin
                check(z, fz);
                check(o, ld & !mode.soft_clock_data_recovery);
                check(tw, mode.multibank ? fz : cr);
                check(th, mode.multibank & ld);
                check(fo, mode.multibank & cr);
                check(vco, tp);
            end
        end
        if (rxp !== rxp_q) begin
            if (since >= 0) check(since % 64, 0);
            since = 1;
        end else begin
            since++;
        end
        rxp_q = rxp;
    end

    initial begin
        void'($urandom(32'h3a38));
        reset_n = 1'b0;
        mode = '0;
        words = '0;
        fails = 0;
        checks = 0;
        skip = 0;
        since = -1000;
        r = -1;
        anch = 1'b0;
        repeat (6) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        since = -1000;
        repeat (95) @(posedge sys_clk);
        #1 check(lk, 1'b0);
        repeat (10) @(posedge sys_clk);
        #1 check(lk, 1'b1);
        check(anch, 1'b1);
        words[7:0] = 8'h01;
        repeat (256) @(posedge sys_clk);
        #1;
        for (int k = 0; k < 8; k++) if (rxp[7:0] === rotl(8'h01, k)) r = k;
        check(r >= 0, 1'b1);
        $display("test align done");
        for (int m = 0; m < 8; m++) begin
            mode = epsc_mode_t'(m[2:0]);
            skip = 3;
            for (int n = 0; n < 18; n++) words[n*8 +: 8] = 8'($urandom);
            repeat (256) @(posedge sys_clk);
            #1;
            for (int n = 0; n < 18; n++) check(rxp[n*8 +: 8], rotl(words[n*8 +: 8], r));
            $display("test mode %0d done", m);
        end
        finish_test();
    end
endmodule : tb_top

`default_nettype wire
